//--- design/cmd_decode_cfg.svh
// ----------------------------------------------------------------------
// Overview of operation
// - Byte 5 bit 7 set loads bits 2..0 as the ADC reference, else kept.
// - Byte 5 bits 2..1 pick the module level: 11 4.096V down to 00 off.
// - Byte 5 bit 0 picks the reference: 1 internal module, 0 supply.
// - Edge settings change and the flag clears only when byte 6 bit 7 is set.
// - Byte 6 bit 4 set loads bit 3 as the rising-edge enable.
// - Byte 6 bit 2 set loads bit 1 as the falling-edge enable.
// - Byte 6 bit 0 set clears the detection flag unless an enabled edge lands in that cycle, 0 leaves it alone.
// - Byte 7 bit 7 set loads new pin settings from byte 8, else kept.
// - A pin-zero output in general-purpose mode drives byte 8 bit 4.
// - Byte 8 bit 3 is pin-zero direction, 1 in, used in gpio mode only.
// - Byte 8 bits 2..0: 000 gpio, 001 suspend, 010 rx LED, rest ignored.
// - Command code 0x60 in byte 0 marks the run-time settings command.
// - Settings live in volatile flops and return to defaults on reset.
// - A completed command answers 0x60 in byte 0 and 0x00 in byte 1.
// ----------------------------------------------------------------------
`ifndef CMD_DECODE_CFG_SVH
`define CMD_DECODE_CFG_SVH

// ----------------------------------------------------------------------
// Command and answer codes
// ----------------------------------------------------------------------
`define CMD_CODE 8'h60
`define RESP_OK 8'h00

// ----------------------------------------------------------------------
// Register byte offsets
// ----------------------------------------------------------------------
`define OFF_CMD0 8'h00
`define OFF_CMD1 8'h04
`define OFF_CMD2 8'h08
`define OFF_EXEC 8'h0c
`define OFF_RESP 8'h10
`define OFF_STAT 8'h14

// ----------------------------------------------------------------------
// Byte lanes and bit positions
// ----------------------------------------------------------------------
`define LANE0 2'h0
`define LANE1 2'h1
`define LANE2 2'h2
`define LANE3 2'h3
`define LOAD_B 7
`define LVL_HI 2
`define LVL_LO 1
`define SRC_B 0
`define RISE_LD_B 4
`define RISE_VAL_B 3
`define FALL_LD_B 2
`define FALL_VAL_B 1
`define CLR_B 0
`define GP_VAL_B 4
`define GP_DIR_B 3
`define DES_HI 2
`define DES_LO 0

// ----------------------------------------------------------------------
// Pin-zero designations
// ----------------------------------------------------------------------
`define DES_GPIO 3'h0
`define DES_SUSP 3'h1
`define DES_URX 3'h2

// ----------------------------------------------------------------------
// Power-up defaults
// ----------------------------------------------------------------------
`define RST_ADC 3'h0
`define RST_EDGE 2'h0
`define RST_GP0 5'h08
`define RST_RESP 16'h0000
`define RST_WORD 32'h00000000
`define STAT_PAD 20'h00000

`endif

//--- design/cmd_decode_pkg.sv
package cmd_decode_pkg;
	// ADC reference selection as loaded from byte 5
	typedef struct packed {
		logic [1:0] level;
		logic internal_src;
	} adc_ref_t;

	// Edge enables of the detection module
	typedef struct packed {
		logic rise_en;
		logic fall_en;
	} edge_cfg_t;

	// Pin-zero run-time settings
	typedef struct packed {
		logic value;
		logic dir_in;
		logic [2:0] desig;
	} gp0_cfg_t;
endpackage

//--- design/intr_edge_detect.sv
`timescale 1ns/1ps
`default_nettype none
module intr_edge_detect import cmd_decode_pkg::*; (
	input wire logic pclk, // Bus clock
	input wire logic presetn, // Async reset, active low
	input wire logic pin, // Detection pin, asynchronous
	input wire edge_cfg_t cfg, // Edge enables
	input wire logic clear, // Clear request pulse
	output logic flag // Sticky detection flag
);
	logic s1_q;
	logic s2_q;
	logic s3_q;
	logic flag_q;
	logic set;

	// Two-stage synchroniser plus a history stage for edges
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			s1_q <= 1'b0;
			s2_q <= 1'b0;
			s3_q <= 1'b0;
		end else begin
			s1_q <= pin;
			s2_q <= s1_q;
			s3_q <= s2_q;
		end
	end

	// Only the settled stages feed the edge compare
	assign set = (cfg.rise_en & s2_q & ~s3_q) |
		(cfg.fall_en & ~s2_q & s3_q);

	// Set beats clear so an edge in the clear cycle is kept
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			flag_q <= 1'b0;
		end else if (set) begin
			flag_q <= 1'b1;
		end else if (clear) begin
			flag_q <= 1'b0;
		end
	end

	assign flag = flag_q;

	default clocking cb @(posedge pclk); endclocking
	default disable iff (!presetn);

	a_flag_set_edge: assert property (
		set |=> flag_q)
		else $error("flag not set after enabled edge");

	a_flag_clear_req: assert property (
		clear && !set |=> !flag_q)
		else $error("flag not cleared on request");

	a_flag_holds: assert property (
		!set && !clear |=> flag_q == $past(flag_q))
		else $error("flag changed without cause");
endmodule
`default_nettype wire

//--- design/runtime_settings_cmd_decode.sv
// Implementation choices: the APB slave port and the placing of the registers.
`timescale 1ns/1ps
`default_nettype none
`include "cmd_decode_cfg.svh"
module runtime_settings_cmd_decode import cmd_decode_pkg::*; (
	input wire logic pclk, // Bus clock, 20 MHz
	input wire logic presetn, // Async reset, active low
	input wire logic psel, // APB select
	input wire logic penable, // APB access phase
	input wire logic pwrite, // APB direction, high for write
	input wire logic [7:0] paddr, // APB byte address
	input wire logic [31:0] pwdata, // APB write data
	output logic [31:0] prdata, // APB read data
	output logic pready, // APB ready
	output logic pslverr, // APB error, unmapped address
	input wire logic intr_pin, // Interrupt detection pin
	input wire logic gp0_in, // Pin zero input level
	input wire logic suspend_state, // Suspend level from USB logic
	input wire logic uart_rx_led, // Rx activity level from UART
	output logic gp0_out, // Pin zero output level
	output logic gp0_oe_n, // Pin zero drive enable, low drives
	output logic [1:0] adc_vrm_level, // Reference module level code
	output logic adc_ref_internal, // 1 internal module, 0 supply
	output logic intr_flag, // Sticky detection flag
	output logic cmd_done // One-cycle pulse on completion
);
	// ------------------------------------------------------------------
	// Helpers
	// ------------------------------------------------------------------
	function automatic logic [7:0] byte_sel(input logic [31:0] w,
		input logic [1:0] lane);
		byte_sel = w[{lane, 3'h0} +: 8];
	endfunction

	function automatic logic addr_ok(input logic [7:0] a);
		addr_ok = (a == `OFF_CMD0) || (a == `OFF_CMD1) ||
			(a == `OFF_CMD2) || (a == `OFF_EXEC) ||
			(a == `OFF_RESP) || (a == `OFF_STAT);
	endfunction

	// ------------------------------------------------------------------
	// State
	// ------------------------------------------------------------------
	logic [31:0] cmd0_q;
	logic [31:0] cmd1_q;
	logic [31:0] cmd2_q;
	logic [15:0] resp_q;
	adc_ref_t adc_q;
	edge_cfg_t edge_q;
	gp0_cfg_t gp0_q;
	logic gin1_q;
	logic gin2_q;
	logic pready_q;
	logic pslverr_q;
	logic [31:0] prdata_q;
	logic [31:0] rd_d;
	logic gp0_out_q;
	logic gp0_oe_n_q;
	logic gp0_out_d;
	logic gp0_oe_n_d;
	logic cmd_done_q;
	logic flag;
	logic setup;
	logic wr;
	logic exec;
	logic cmd_ok;
	logic apply;
	logic clear;
	logic [7:0] b0;
	logic [7:0] b5;
	logic [7:0] b6;
	logic [7:0] b7;
	logic [7:0] b8;

	// ------------------------------------------------------------------
	// APB slave
	// ------------------------------------------------------------------
	// Answer is always one access cycle; data is fixed at setup
	assign setup = psel & ~penable;
	assign wr = psel & penable & pready_q & pwrite;
	assign exec = wr && (paddr == `OFF_EXEC);

	// Ready and error are pulsed for the single access cycle
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pready_q <= 1'b0;
			pslverr_q <= 1'b0;
		end else begin
			pready_q <= setup;
			pslverr_q <= setup & ~addr_ok(paddr);
		end
	end

	// Read mux; status reflects the state one cycle before the access
	always_comb begin
		rd_d = `RST_WORD;
		unique case (paddr)
			`OFF_CMD0: rd_d = cmd0_q;
			`OFF_CMD1: rd_d = cmd1_q;
			`OFF_CMD2: rd_d = cmd2_q;
			`OFF_RESP: rd_d = {16'h0000, resp_q};
			`OFF_STAT: rd_d = {`STAT_PAD, gin2_q, gp0_q, flag,
				edge_q, adc_q};
			default: rd_d = `RST_WORD;
		endcase
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			prdata_q <= `RST_WORD;
		end else if (setup) begin
			prdata_q <= pwrite ? `RST_WORD : rd_d;
		end
	end

	// Command report words; bytes 0..3, 4..7 and 8
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			cmd0_q <= `RST_WORD;
			cmd1_q <= `RST_WORD;
			cmd2_q <= `RST_WORD;
		end else if (wr) begin
			if (paddr == `OFF_CMD0) cmd0_q <= pwdata;
			if (paddr == `OFF_CMD1) cmd1_q <= pwdata;
			if (paddr == `OFF_CMD2) cmd2_q <= pwdata;
		end
	end

	// ------------------------------------------------------------------
	// Command decode
	// ------------------------------------------------------------------
	assign b0 = byte_sel(cmd0_q, `LANE0);
	assign b5 = byte_sel(cmd1_q, `LANE1);
	assign b6 = byte_sel(cmd1_q, `LANE2);
	assign b7 = byte_sel(cmd1_q, `LANE3);
	assign b8 = byte_sel(cmd2_q, `LANE0);
	assign cmd_ok = (b0 == `CMD_CODE);
	assign apply = exec & cmd_ok;
	assign clear = apply & b6[`LOAD_B] & b6[`CLR_B];

	// ADC reference; plain flops so reset restores defaults
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			adc_q <= `RST_ADC;
		end else if (apply && b5[`LOAD_B]) begin
			adc_q.level <= b5[`LVL_HI:`LVL_LO];
			adc_q.internal_src <= b5[`SRC_B];
		end
	end

	// Edge enables, each behind its own load bit
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			edge_q <= `RST_EDGE;
		end else if (apply && b6[`LOAD_B]) begin
			if (b6[`RISE_LD_B]) edge_q.rise_en <= b6[`RISE_VAL_B];
			if (b6[`FALL_LD_B]) edge_q.fall_en <= b6[`FALL_VAL_B];
		end
	end

	// Pin zero; unknown designations keep the old one
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			gp0_q <= `RST_GP0;
		end else if (apply && b7[`LOAD_B]) begin
			gp0_q.value <= b8[`GP_VAL_B];
			gp0_q.dir_in <= b8[`GP_DIR_B];
			if (b8[`DES_HI:`DES_LO] <= `DES_URX)
				gp0_q.desig <= b8[`DES_HI:`DES_LO];
		end
	end

	// Answer words and completion pulse
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			resp_q <= `RST_RESP;
			cmd_done_q <= 1'b0;
		end else begin
			cmd_done_q <= apply;
			if (apply) resp_q <= {`RESP_OK, `CMD_CODE};
		end
	end

	// ------------------------------------------------------------------
	// Pin zero and detection
	// ------------------------------------------------------------------
	// Pin input is asynchronous, so it is synchronised before status
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			gin1_q <= 1'b0;
			gin2_q <= 1'b0;
		end else begin
			gin1_q <= gp0_in;
			gin2_q <= gin1_q;
		end
	end

	// Direction only matters in gpio mode; alternates always drive
	always_comb begin
		gp0_out_d = 1'b0;
		gp0_oe_n_d = 1'b1;
		unique case (gp0_q.desig)
			`DES_GPIO: begin
				gp0_out_d = gp0_q.value;
				gp0_oe_n_d = gp0_q.dir_in;
			end
			`DES_SUSP: begin
				gp0_out_d = suspend_state;
				gp0_oe_n_d = 1'b0;
			end
			`DES_URX: begin
				gp0_out_d = uart_rx_led;
				gp0_oe_n_d = 1'b0;
			end
			default: begin
				gp0_out_d = 1'b0;
				gp0_oe_n_d = 1'b1;
			end
		endcase
	end

	// Registered pin drive keeps outputs glitch free
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			gp0_out_q <= 1'b0;
			gp0_oe_n_q <= 1'b1;
		end else begin
			gp0_out_q <= gp0_out_d;
			gp0_oe_n_q <= gp0_oe_n_d;
		end
	end

	intr_edge_detect u_detect (
		.pclk(pclk),
		.presetn(presetn),
		.pin(intr_pin),
		.cfg(edge_q),
		.clear(clear),
		.flag(flag)
	);

	// ------------------------------------------------------------------
	// Outputs
	// ------------------------------------------------------------------
	assign prdata = prdata_q;
	assign pready = pready_q;
	assign pslverr = pslverr_q;
	assign gp0_out = gp0_out_q;
	assign gp0_oe_n = gp0_oe_n_q;
	assign adc_vrm_level = adc_q.level;
	assign adc_ref_internal = adc_q.internal_src;
	assign intr_flag = flag;
	assign cmd_done = cmd_done_q;

	// ------------------------------------------------------------------
	// Checks
	// ------------------------------------------------------------------
	default clocking cb @(posedge pclk); endclocking
	default disable iff (!presetn);

	sequence s_exec_ok;
		exec && cmd_ok;
	endsequence

	sequence s_answer;
		cmd_done && resp_q == {`RESP_OK, `CMD_CODE} ##1 !cmd_done;
	endsequence

	sequence s_gpio_out;
		gp0_q.desig == `DES_GPIO && !gp0_q.dir_in;
	endsequence

	a_adc_ref_load: assert property (
		apply && b5[`LOAD_B] |=> adc_q == $past(b5[2:0]))
		else $error("ADC reference not loaded");

	a_adc_ref_keep: assert property (
		!(apply && b5[`LOAD_B]) |=> $stable(adc_q))
		else $error("ADC reference changed without load");

	a_vrm_level_out: assert property (
		apply && b5[`LOAD_B] |=> adc_vrm_level == $past(b5[2:1]))
		else $error("reference level output wrong");

	a_ref_source_out: assert property (
		apply && b5[`LOAD_B] |=> adc_ref_internal == $past(b5[0]))
		else $error("reference source output wrong");

	a_edge_cfg_keep: assert property (
		!(apply && b6[`LOAD_B]) |=> $stable(edge_q))
		else $error("edge settings changed without load");

	a_rise_en_load: assert property (
		apply && b6[`LOAD_B] && b6[4] |=> edge_q.rise_en == $past(b6[3]))
		else $error("rising enable not loaded");

	a_fall_en_load: assert property (
		apply && b6[`LOAD_B] && b6[2] |=> edge_q.fall_en == $past(b6[1]))
		else $error("falling enable not loaded");

	a_flag_clear_cmd: assert property (
		clear |-> apply && b6[7] && b6[0])
		else $error("flag clear without command");

	a_gp_cfg_keep: assert property (
		!(apply && b7[`LOAD_B]) |=> $stable(gp0_q))
		else $error("pin settings changed without load");

	a_gpio_drive: assert property (
		s_gpio_out |=> gp0_out == $past(gp0_q.value) && !gp0_oe_n)
		else $error("gpio output value not driven");

	a_gpio_input: assert property (
		gp0_q.desig == `DES_GPIO && gp0_q.dir_in |=> gp0_oe_n)
		else $error("input pin is driven");

	a_desig_ignore: assert property (
		apply && b7[`LOAD_B] && b8[2:0] > `DES_URX
		|=> $stable(gp0_q.desig))
		else $error("illegal designation accepted");

	a_cmd_code_gate: assert property (
		exec && !cmd_ok |=> $stable(adc_q) && $stable(gp0_q) && !cmd_done)
		else $error("foreign command code executed");

	a_resp_echo: assert property (
		s_exec_ok |=> s_answer)
		else $error("answer words or completion pulse wrong");
endmodule
`default_nettype wire

//--- verif/cmd_host.sv
`timescale 1ns/1ps
`default_nettype none
`include "cmd_decode_cfg.svh"
// ----------------------------------------------------------------------
// Host side: sends settings reports over the register bus
// ----------------------------------------------------------------------
module cmd_host (
	input wire logic pclk, // Bus clock
	output logic psel, // Select
	output logic penable, // Access phase
	output logic pwrite, // Direction
	output logic [7:0] paddr, // Byte address
	output logic [31:0] pwdata, // Write data
	input wire logic [31:0] prdata, // Read data
	input wire logic pready, // Ready
	input wire logic pslverr // Error
);
	// Bus idles with nothing selected
	initial {psel, penable, pwrite, paddr, pwdata} = '0;

	// One transfer; the idle edge first keeps each drive to one per step
	task automatic xfer(input logic w, input logic [7:0] a,
		input logic [31:0] d, output logic [31:0] rd, output logic err);
		@(posedge pclk);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		@(posedge pclk);
		while (pready !== 1'b1) @(posedge pclk);
		rd = prdata;
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask

	// Whole report: bytes 0..3, 4..7, byte 8, then the run strobe
	task automatic send(input logic [31:0] w0, input logic [31:0] w1,
		input logic [7:0] b8);
		logic [31:0] rd;
		logic err;
		xfer(1'b1, `OFF_CMD0, w0, rd, err);
		xfer(1'b1, `OFF_CMD1, w1, rd, err);
		xfer(1'b1, `OFF_CMD2, {24'h0, b8}, rd, err);
		xfer(1'b1, `OFF_EXEC, 32'h1, rd, err);
	endtask
endmodule
`default_nettype wire

//--- verif/test_runtime_settings_cmd_decode.sv
`timescale 1ns/1ps
`default_nettype none
`include "cmd_decode_cfg.svh"
module test_runtime_settings_cmd_decode import cmd_decode_pkg::*;;
	logic pclk, presetn, psel, penable, pwrite, pready, pslverr, err;
	logic intr_pin, gp0_in, suspend_state, uart_rx_led, gp0_out, gp0_oe_n;
	logic adc_ref_internal, intr_flag, cmd_done;
	logic [7:0] paddr;
	logic [31:0] pwdata, prdata, seed, rd;
	logic [1:0] adc_vrm_level;
	int n_mismatch, n_tests, n_done, e_done, cyc;
	adc_ref_t e_adc;
	gp0_cfg_t e_gp;
	edge_cfg_t e_edge;
	logic e_flag;

	runtime_settings_cmd_decode uut(.pclk(pclk), .presetn(presetn),
		.psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
		.pwdata(pwdata), .prdata(prdata), .pready(pready),
		.pslverr(pslverr), .intr_pin(intr_pin), .gp0_in(gp0_in),
		.suspend_state(suspend_state), .uart_rx_led(uart_rx_led),
		.gp0_out(gp0_out), .gp0_oe_n(gp0_oe_n),
		.adc_vrm_level(adc_vrm_level), .adc_ref_internal(adc_ref_internal),
		.intr_flag(intr_flag), .cmd_done(cmd_done));
	cmd_host host(.pclk(pclk), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
		.pready(pready), .pslverr(pslverr));

	// ------------------------------------------------------------------
	// Helpers
	// ------------------------------------------------------------------
	function automatic logic [31:0] lfsr(input logic [31:0] s);
		return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
	endfunction

	// Expected {drive enable low, level}; alternate modes always drive
	function automatic logic [1:0] pin_exp(input gp0_cfg_t g,
		input logic s, input logic u);
		if (g.desig == `DES_SUSP) return {1'b0, s};
		if (g.desig == `DES_URX) return {1'b0, u};
		return {g.dir_in, g.value};
	endfunction

	task automatic chk(input string nm, input logic [31:0] e,
		input logic [31:0] g);
		n_tests++;
		if (g !== e) begin
			n_mismatch++;
			$display("BAD %s exp %h got %h", nm, e, g);
		end
	endtask

	task automatic summarize();
		$display("checks %0d mismatches %0d", n_tests, n_mismatch);
		if (n_mismatch == 0 && n_tests > 0) $display("[ PASS ]");
		else $display("[ FAIL ]");
		$finish;
	endtask

	task automatic check_state();
		logic [1:0] p;
		p = pin_exp(e_gp, suspend_state, uart_rx_led);
		chk("level", {30'h0, e_adc.level}, {30'h0, adc_vrm_level});
		chk("src", 32'(e_adc.internal_src), 32'(adc_ref_internal));
		chk("oe_n", {31'h0, p[1]}, {31'h0, gp0_oe_n});
		if (p[1] == 1'b0) chk("out", {31'h0, p[0]}, {31'h0, gp0_out});
		chk("flag", {31'h0, e_flag}, {31'h0, intr_flag});
		chk("done", e_done, n_done);
	endtask

	// Send, update the model for a valid code, let outputs settle
	task automatic run(input logic [31:0] w0, input logic [31:0] w1,
		input logic [7:0] b8);
		logic [31:0] st;
		logic se;
		host.send(w0, w1, b8);
		if (w0[7:0] == `CMD_CODE) begin
			e_done++;
			if (w1[15]) e_adc = w1[10:8];
			if (w1[23] && w1[20]) e_edge.rise_en = w1[19];
			if (w1[23] && w1[18]) e_edge.fall_en = w1[17];
			if (w1[23] && w1[16]) e_flag = 1'b0;
			if (w1[31]) e_gp.value = b8[4];
			if (w1[31]) e_gp.dir_in = b8[3];
			if (w1[31] && b8[2:0] <= `DES_URX) e_gp.desig = b8[2:0];
		end
		repeat (3) @(posedge pclk);
		check_state();
		// Status is the only window on edge enables and the pin input
		host.xfer(1'b0, `OFF_STAT, 32'h0, st, se);
		chk("stat", {20'h0, gp0_in, e_gp, e_flag, e_edge, e_adc}, st);
	endtask

	task automatic pin_to(input logic v, input logic f);
		intr_pin <= v;
		repeat (8) @(posedge pclk);
		e_flag = f;
		check_state();
	endtask

	task automatic defaults();
		e_adc = `RST_ADC;
		e_gp = `RST_GP0;
		e_edge = `RST_EDGE;
		e_flag = 1'b0;
	endtask

	// ------------------------------------------------------------------
	// Clock, pulse count and hang guard
	// ------------------------------------------------------------------
	initial begin
		pclk = 1'b0;
		forever #25 pclk = ~pclk;
	end

	// Ceiling is several times the few hundred cycles the run needs
	always @(posedge pclk) begin
		cyc++;
		if (cmd_done === 1'b1) n_done++;
		if (cyc == 4000) begin
			n_mismatch++;
			summarize();
		end
	end

	// ------------------------------------------------------------------
	// Main sequence
	// ------------------------------------------------------------------
	initial begin
		{presetn, intr_pin, gp0_in, suspend_state, uart_rx_led} = '0;
		seed = 32'd80273;
		defaults();
		repeat (8) @(posedge pclk);
		presetn <= 1'b1;
		check_state();
		host.xfer(1'b0, `OFF_RESP, 32'h0, rd, err);
		chk("resp_rst", 32'h0, rd);
		// First five walk every designation and levels 00 to 10, then random mixes
		for (int i = 0; i < 16; i++) begin
			seed = lfsr(seed);
			suspend_state <= seed[20];
			uart_rx_led <= seed[21];
			gp0_in <= seed[22];
			if (i < 5) run({seed[31:8], `CMD_CODE},
				{16'h8000, 5'h10, i[2:0], seed[7:0]}, {5'h02, i[2:0]});
			else run({seed[31:8], `CMD_CODE}, seed, seed[15:8]);
		end
		host.xfer(1'b0, `OFF_RESP, 32'h0, rd, err);
		chk("resp", {16'h0, `RESP_OK, `CMD_CODE}, rd);
		run(32'h61, 32'h80958700, 8'h1b);
		$display("test settings done");
		run({24'h0, `CMD_CODE}, 32'h009c0000, 8'h00);
		pin_to(1'b1, 1'b1);
		run({24'h0, `CMD_CODE}, 32'h00010000, 8'h00);
		run({24'h0, `CMD_CODE}, 32'h00960000, 8'h00);
		pin_to(1'b0, 1'b1);
		run({24'h0, `CMD_CODE}, 32'h00810000, 8'h00);
		pin_to(1'b1, 1'b0);
		pin_to(1'b0, 1'b1);
		$display("test detection done");
		host.xfer(1'b0, 8'h20, 32'h0, rd, err);
		chk("slverr", 32'h1, {31'h0, err});
		chk("bad_rd", 32'h0, rd);
		$display("test unmapped done");
		presetn <= 1'b0;
		repeat (2) @(posedge pclk);
		defaults();
		check_state();
		presetn <= 1'b1;
		host.xfer(1'b0, `OFF_RESP, 32'h0, rd, err);
		chk("resp_rst2", 32'h0, rd);
		$display("test reset done");
		summarize();
	end
endmodule
`default_nettype wire
